// file: pwm_vib_pkg.sv
// constants, field layouts and types for the dual pulse generator and
// vibrator motor control block
// assumes a 20 MHz system clock and a 32 bit AXI4-Lite register bus
package pwm_vib_pkg;

   // ------------------------------------------------------------
   // register byte offsets
   // ------------------------------------------------------------
   localparam int ADDR_W = 8;
   localparam logic [7:0] OFF_PULSE_ACTION = 8'h00;
   localparam logic [7:0] OFF_RISE_A = 8'h04;
   localparam logic [7:0] OFF_FALL_A = 8'h08;
   localparam logic [7:0] OFF_RISE_B = 8'h0c;
   localparam logic [7:0] OFF_FALL_B = 8'h10;
   localparam logic [7:0] OFF_MISC_CONFIG = 8'h14;
   localparam logic [7:0] OFF_MOTOR_CTRL = 8'h18;
   localparam logic [7:0] OFF_MOTOR_CFG = 8'h1c;
   localparam logic [7:0] OFF_MOTOR_ACTION = 8'h20;
   localparam logic [7:0] OFF_STATUS = 8'h24;

   // ------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------
   localparam int BIT_CLK_EN_A = 0;
   localparam int BIT_CLK_EN_B = 1;
   localparam int BIT_START_A = 2;
   localparam int BIT_START_B = 3;
   localparam int BIT_STOP_A = 4;
   localparam int BIT_STOP_B = 5;
   localparam int BIT_LEN_SEL = 7;
   localparam int BIT_MODE_SEL = 0;
   localparam int BIT_MOTOR_START = 0;
   localparam int BIT_MOTOR_STOP = 1;

   // ------------------------------------------------------------
   // reset values and responses
   // ------------------------------------------------------------
   localparam logic [6:0] RISE_RESET = 7'h01;
   localparam logic [6:0] FALL_RESET = 7'h01;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ------------------------------------------------------------
   // timing
   // ------------------------------------------------------------
   localparam int PERIOD_LONG = 128;
   localparam int PERIOD_SHORT = 64;
   localparam logic [6:0] LAST_LONG = 7'(PERIOD_LONG - 1);
   localparam logic [6:0] LAST_SHORT = 7'(PERIOD_SHORT - 1);
   localparam int CLK_MHZ = 20;
   localparam int RAMP_ON_US = 500;
   localparam int RAMP_OFF_US = 2000;
   localparam int RAMP_ON_CYCLES = RAMP_ON_US * CLK_MHZ;
   localparam int RAMP_OFF_CYCLES = RAMP_OFF_US * CLK_MHZ;
   localparam int RAMP_STEPS = 255;

   // ------------------------------------------------------------
   // types
   // ------------------------------------------------------------
   typedef struct packed {
      logic len_sel;
      logic [6:0] rise;
      logic [6:0] fall;
   } pwm_cfg_type;

   typedef enum logic [3:0] {
      MOTOR_IDLE = 4'h1,
      MOTOR_RISE = 4'h2,
      MOTOR_HOLD = 4'h4,
      MOTOR_FALL = 4'h8
   } motor_state_type;

endpackage

// file: pwm_channel.sv
// one pulse channel: period counter on the gated slow tick and the
// output compare against the rise and fall positions
// assumes tick is a one-cycle pulse per slow clock rising edge
`timescale 1ns/1ns
module pwm_channel (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // control
   input wire logic tick,
   input wire logic clk_en,
   input wire logic start,
   input wire logic stop,
   input wire pwm_vib_pkg::pwm_cfg_type cfg,
   // state and output
   output logic running,
   output logic [6:0] count,
   output logic pwm
);
   logic [6:0] last;

   assign last = cfg.len_sel ? pwm_vib_pkg::LAST_LONG :
                 pwm_vib_pkg::LAST_SHORT; // see [R1]

   // stop wins over a start in the same write
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         running <= 1'b0;
      end else if (stop) begin
         running <= 1'b0; // see [R3]
      end else if (start) begin
         running <= 1'b1; // see [R3]
      end
   end

   // start clears the count so two channels started together align
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         count <= 7'h00;
      end else if (start) begin
         count <= 7'h00; // see [R8]
      end else if (running && clk_en && tick) begin
         if (count >= last) begin
            count <= 7'h00; // see [R13]
         end else begin
            count <= count + 7'h01; // see [R2]
         end
      end
   end

   // no sleep gating: the output keeps going in every power state
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pwm <= 1'b0;
      end else if (!running) begin
         pwm <= 1'b0;
      end else if (cfg.rise == cfg.fall) begin
         pwm <= 1'b1; // see [R6] [R9]
      end else begin
         pwm <= (count >= cfg.rise) && (count < cfg.fall); // see [R5] [R13]
      end
   end
endmodule

// file: motor_ramp.sv
// vibrator drive: soft ramp of the drive level and the duty waveform
// assumes tick is a one-cycle pulse per slow clock rising edge
`timescale 1ns/1ns
module motor_ramp #(
   parameter int ON_STEP = 39,
   parameter int OFF_STEP = 156
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // control
   input wire logic tick,
   input wire logic start,
   input wire logic stop,
   input wire logic mode,
   input wire logic [1:0] duty,
   input wire logic [1:0] rate,
   // state and outputs
   output pwm_vib_pkg::motor_state_type state,
   output logic [7:0] level,
   output logic drive
);
   logic [15:0] step_cnt;
   logic [7:0] phase;
   logic [1:0] quarter;
   logic step_due;

   assign step_due = (state == pwm_vib_pkg::MOTOR_RISE) ?
      (step_cnt >= 16'(ON_STEP - 1)) : (step_cnt >= 16'(OFF_STEP - 1));

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state <= pwm_vib_pkg::MOTOR_IDLE;
      end else begin
         case (state)
            pwm_vib_pkg::MOTOR_IDLE: begin
               if (start && !stop && mode) state <= pwm_vib_pkg::MOTOR_RISE;
            end
            pwm_vib_pkg::MOTOR_RISE: begin
               if (stop || !mode) state <= pwm_vib_pkg::MOTOR_FALL;
               else if (level == 8'hff) state <= pwm_vib_pkg::MOTOR_HOLD;
            end
            pwm_vib_pkg::MOTOR_HOLD: begin
               if (stop || !mode) state <= pwm_vib_pkg::MOTOR_FALL; // see [R11]
            end
            pwm_vib_pkg::MOTOR_FALL: begin
               if (start && !stop && mode) state <= pwm_vib_pkg::MOTOR_RISE;
               else if (level == 8'h00) state <= pwm_vib_pkg::MOTOR_IDLE;
            end
            default: state <= pwm_vib_pkg::MOTOR_IDLE;
         endcase
      end
   end

   // level steps bound the ramps to 500 us up and 2 ms down
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         step_cnt <= 16'h0000;
         level <= 8'h00;
      end else if (state == pwm_vib_pkg::MOTOR_RISE ||
                   state == pwm_vib_pkg::MOTOR_FALL) begin
         if (step_due) begin
            step_cnt <= 16'h0000;
            if (state == pwm_vib_pkg::MOTOR_RISE && level != 8'hff)
               level <= level + 8'h01; // see [R12]
            else if (state == pwm_vib_pkg::MOTOR_FALL && level != 8'h00)
               level <= level - 8'h01; // see [R12]
         end else begin
            step_cnt <= step_cnt + 16'h0001;
         end
      end else begin
         step_cnt <= 16'h0000;
      end
   end

   // waveform period is 32 ticks doubled per rate step
   always_ff @(posedge clk or posedge rst) begin
      if (rst) phase <= 8'h00;
      else if (tick) phase <= phase + 8'h01;
   end

   always_comb begin
      case (rate)
         2'h0: quarter = phase[4:3];
         2'h1: quarter = phase[5:4];
         2'h2: quarter = phase[6:5];
         default: quarter = phase[7:6];
      endcase
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) drive <= 1'b0;
      else drive <= mode && (level != 8'h00) && (quarter <= duty); // see [R10]
   end
endmodule

// file: pwm_vib_top.sv
// top of the dual pulse generator and vibrator motor control block,
// with its AXI4-Lite register slave and slow clock synchroniser
// assumes the slow clock arrives asynchronously on a pin and that
// software keeps the programming order and value ranges it must
//
// Decided for this implementation: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ns

// Behaviour
// [R1] each channel picks its own period, 128 or 64 slow clock counts
// [R2] each channel has its own counter on the gated 32768 Hz clock
// [R3] start bit begins generation, stop bit ends it, same action reg
// [R4] software enables the counter clock before start, stops before disable
// [R5] 7-bit rise and fall positions set the edges within each period
// [R6] equal rise and fall positions hold the output constantly high
// [R7] software keeps fall at least rise, and rise above zero
// [R8] both starts in one write start the counters together
// [R9] outputs keep running in the low-power sleep state
// [R10] mode bit selects vibrator use; 2-bit duty and rate shape drive
// [R11] motor start bit starts the drive, motor stop bit stops it
// [R12] drive ramps on within 500 us and off within 2 ms
// [R13] counter wraps after the period; high from rise until fall
// [R14] action bits act on a written one; a written zero does nothing
module pwm_vib_top #(
   parameter int RAMP_ON_CYCLES = pwm_vib_pkg::RAMP_ON_CYCLES,
   parameter int RAMP_OFF_CYCLES = pwm_vib_pkg::RAMP_OFF_CYCLES
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // axi4-lite write address
   input wire logic awvalid,
   output logic awready,
   input wire logic [7:0] awaddr,
   input wire logic [2:0] awprot,
   // axi4-lite write data
   input wire logic wvalid,
   output logic wready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   // axi4-lite write response
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   // axi4-lite read address
   input wire logic arvalid,
   output logic arready,
   input wire logic [7:0] araddr,
   input wire logic [2:0] arprot,
   // axi4-lite read data
   output logic rvalid,
   input wire logic rready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   // slow clock pin
   input wire logic clk32k_in,
   // pulse outputs
   output logic pwm_out_a,
   output logic pwm_out_b,
   // regulator and motor drive
   output logic motor_mode_sel,
   output logic [7:0] motor_level,
   output logic motor_drive
);
   // ------------------------------------------------------------
   // derived step intervals
   // ------------------------------------------------------------
   // a longest time rounds down, but never below one cycle
   localparam int ON_RAW = RAMP_ON_CYCLES / pwm_vib_pkg::RAMP_STEPS;
   localparam int OFF_RAW = RAMP_OFF_CYCLES / pwm_vib_pkg::RAMP_STEPS;
   localparam int ON_STEP = (ON_RAW < 1) ? 1 : ON_RAW;
   localparam int OFF_STEP = (OFF_RAW < 1) ? 1 : OFF_RAW;

   // ------------------------------------------------------------
   // declarations
   // ------------------------------------------------------------
   logic [2:0] slow_sync;
   logic slow_level;
   logic tick;

   logic aw_held;
   logic [7:0] aw_addr_q;
   logic w_held;
   logic [31:0] w_data_q;
   logic [3:0] w_strb_q;
   logic do_write;
   logic wr_lane;
   logic wr_hit;

   logic wr_action;
   logic wr_rise_a;
   logic wr_fall_a;
   logic wr_rise_b;
   logic wr_fall_b;
   logic wr_misc;
   logic wr_motor_ctrl;
   logic wr_motor_cfg;
   logic wr_motor_action;

   logic counter_clk_en_a;
   logic counter_clk_en_b;
   logic gen_start_a;
   logic gen_start_b;
   logic gen_stop_a;
   logic gen_stop_b;
   logic motor_start;
   logic motor_stop;

   pwm_vib_pkg::pwm_cfg_type cfg_a;
   pwm_vib_pkg::pwm_cfg_type cfg_b;
   logic [1:0] motor_duty_sel;
   logic [1:0] motor_rate_sel;

   logic running_a;
   logic running_b;
   logic [6:0] period_counter_a;
   logic [6:0] period_counter_b;
   pwm_vib_pkg::motor_state_type motor_state;

   logic rd_hit;
   logic [31:0] rd_value;

   // ------------------------------------------------------------
   // slow clock synchroniser
   // ------------------------------------------------------------
   // first stage feeds only the second; a change counts once the
   // second and third agree, which also filters a runt on the pin
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         slow_sync <= 3'h0;
      end else begin
         slow_sync <= {slow_sync[1:0], clk32k_in};
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         slow_level <= 1'b0;
      end else if (slow_sync[1] == slow_sync[2]) begin
         slow_level <= slow_sync[2];
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         tick <= 1'b0;
      end else begin
         tick <= (slow_sync[1] == slow_sync[2]) && slow_sync[2] &&
                 !slow_level;
      end
   end

   // ------------------------------------------------------------
   // axi4-lite write path
   // ------------------------------------------------------------
   // address and data are taken in either order and held until both
   // are present; nothing new is taken while a response is pending
   assign awready = !aw_held && !bvalid;
   assign wready = !w_held && !bvalid;
   assign do_write = aw_held && w_held && !bvalid;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         aw_held <= 1'b0;
         aw_addr_q <= 8'h00;
      end else if (awvalid && awready) begin
         aw_held <= 1'b1;
         aw_addr_q <= awaddr;
      end else if (do_write) begin
         aw_held <= 1'b0;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         w_held <= 1'b0;
         w_data_q <= 32'h0000_0000;
         w_strb_q <= 4'h0;
      end else if (wvalid && wready) begin
         w_held <= 1'b1;
         w_data_q <= wdata;
         w_strb_q <= wstrb;
      end else if (do_write) begin
         w_held <= 1'b0;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         bvalid <= 1'b0;
         bresp <= pwm_vib_pkg::RESP_OKAY;
      end else if (do_write) begin
         bvalid <= 1'b1;
         bresp <= wr_hit ? pwm_vib_pkg::RESP_OKAY :
                  pwm_vib_pkg::RESP_SLVERR;
      end else if (bready) begin
         bvalid <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // write decode
   // ------------------------------------------------------------
   // all fields sit in byte lane 0; other lanes are ignored
   assign wr_lane = do_write && w_strb_q[0];

   always_comb begin
      wr_action = 1'b0;
      wr_rise_a = 1'b0;
      wr_fall_a = 1'b0;
      wr_rise_b = 1'b0;
      wr_fall_b = 1'b0;
      wr_misc = 1'b0;
      wr_motor_ctrl = 1'b0;
      wr_motor_cfg = 1'b0;
      wr_motor_action = 1'b0;
      wr_hit = 1'b1;
      if (aw_addr_q == pwm_vib_pkg::OFF_PULSE_ACTION) begin
         wr_action = wr_lane;
      end else if (aw_addr_q == pwm_vib_pkg::OFF_RISE_A) begin
         wr_rise_a = wr_lane;
      end else if (aw_addr_q == pwm_vib_pkg::OFF_FALL_A) begin
         wr_fall_a = wr_lane;
      end else if (aw_addr_q == pwm_vib_pkg::OFF_RISE_B) begin
         wr_rise_b = wr_lane;
      end else if (aw_addr_q == pwm_vib_pkg::OFF_FALL_B) begin
         wr_fall_b = wr_lane;
      end else if (aw_addr_q == pwm_vib_pkg::OFF_MISC_CONFIG) begin
         wr_misc = wr_lane;
      end else if (aw_addr_q == pwm_vib_pkg::OFF_MOTOR_CTRL) begin
         wr_motor_ctrl = wr_lane;
      end else if (aw_addr_q == pwm_vib_pkg::OFF_MOTOR_CFG) begin
         wr_motor_cfg = wr_lane;
      end else if (aw_addr_q == pwm_vib_pkg::OFF_MOTOR_ACTION) begin
         wr_motor_action = wr_lane;
      end else if (aw_addr_q == pwm_vib_pkg::OFF_STATUS) begin
         wr_hit = 1'b1;
      end else begin
         wr_hit = 1'b0;
      end
   end

   // action bits are one-cycle pulses; a written zero does nothing
   assign gen_start_a = wr_action && w_data_q[pwm_vib_pkg::BIT_START_A]; // see [R14]
   assign gen_start_b = wr_action && w_data_q[pwm_vib_pkg::BIT_START_B]; // see [R14]
   assign gen_stop_a = wr_action && w_data_q[pwm_vib_pkg::BIT_STOP_A]; // see [R14]
   assign gen_stop_b = wr_action && w_data_q[pwm_vib_pkg::BIT_STOP_B]; // see [R14]
   assign motor_start = wr_motor_action &&
                        w_data_q[pwm_vib_pkg::BIT_MOTOR_START]; // see [R11]
   assign motor_stop = wr_motor_action &&
                       w_data_q[pwm_vib_pkg::BIT_MOTOR_STOP]; // see [R11]

   // ------------------------------------------------------------
   // configuration registers
   // ------------------------------------------------------------
   // clock enables are plain levels in the action register
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         counter_clk_en_a <= 1'b0;
         counter_clk_en_b <= 1'b0;
      end else if (wr_action) begin
         counter_clk_en_a <= w_data_q[pwm_vib_pkg::BIT_CLK_EN_A]; // see [R2]
         counter_clk_en_b <= w_data_q[pwm_vib_pkg::BIT_CLK_EN_B]; // see [R2]
      end
   end

   // out-of-range positions are not corrected: software keeps them legal
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cfg_a <= '{1'b1, pwm_vib_pkg::RISE_RESET, pwm_vib_pkg::FALL_RESET};
      end else if (wr_rise_a) begin
         cfg_a.rise <= w_data_q[6:0]; // see [R5]
         cfg_a.len_sel <= w_data_q[pwm_vib_pkg::BIT_LEN_SEL]; // see [R1]
      end else if (wr_fall_a) begin
         cfg_a.fall <= w_data_q[6:0]; // see [R5]
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cfg_b <= '{1'b1, pwm_vib_pkg::RISE_RESET, pwm_vib_pkg::FALL_RESET};
      end else if (wr_rise_b) begin
         cfg_b.rise <= w_data_q[6:0]; // see [R5]
         cfg_b.len_sel <= w_data_q[pwm_vib_pkg::BIT_LEN_SEL]; // see [R1]
      end else if (wr_fall_b) begin
         cfg_b.fall <= w_data_q[6:0]; // see [R5]
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         motor_mode_sel <= 1'b0;
      end else if (wr_misc) begin
         motor_mode_sel <= w_data_q[pwm_vib_pkg::BIT_MODE_SEL]; // see [R10]
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         motor_duty_sel <= 2'h0;
      end else if (wr_motor_ctrl) begin
         motor_duty_sel <= w_data_q[1:0]; // see [R10]
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         motor_rate_sel <= 2'h0;
      end else if (wr_motor_cfg) begin
         motor_rate_sel <= w_data_q[1:0]; // see [R10]
      end
   end

   // ------------------------------------------------------------
   // pulse channels and motor drive
   // ------------------------------------------------------------
   // both channels see the same write pulse, so a joint start is aligned
   pwm_channel chan_a (
      .clk(clk),
      .rst(rst),
      .tick(tick),
      .clk_en(counter_clk_en_a),
      .start(gen_start_a),
      .stop(gen_stop_a),
      .cfg(cfg_a),
      .running(running_a),
      .count(period_counter_a),
      .pwm(pwm_out_a)
   );

   pwm_channel chan_b (
      .clk(clk),
      .rst(rst),
      .tick(tick),
      .clk_en(counter_clk_en_b),
      .start(gen_start_b),
      .stop(gen_stop_b),
      .cfg(cfg_b),
      .running(running_b),
      .count(period_counter_b),
      .pwm(pwm_out_b)
   ); // see [R8]

   motor_ramp #(
      .ON_STEP(ON_STEP),
      .OFF_STEP(OFF_STEP)
   ) motor (
      .clk(clk),
      .rst(rst),
      .tick(tick),
      .start(motor_start),
      .stop(motor_stop),
      .mode(motor_mode_sel),
      .duty(motor_duty_sel),
      .rate(motor_rate_sel),
      .state(motor_state),
      .level(motor_level),
      .drive(motor_drive)
   ); // see [R12]

   // ------------------------------------------------------------
   // axi4-lite read path
   // ------------------------------------------------------------
   always_comb begin
      rd_value = 32'h0000_0000;
      rd_hit = 1'b1;
      if (araddr == pwm_vib_pkg::OFF_PULSE_ACTION) begin
         rd_value[pwm_vib_pkg::BIT_CLK_EN_A] = counter_clk_en_a;
         rd_value[pwm_vib_pkg::BIT_CLK_EN_B] = counter_clk_en_b;
      end else if (araddr == pwm_vib_pkg::OFF_RISE_A) begin
         rd_value[7:0] = {cfg_a.len_sel, cfg_a.rise};
      end else if (araddr == pwm_vib_pkg::OFF_FALL_A) begin
         rd_value[6:0] = cfg_a.fall;
      end else if (araddr == pwm_vib_pkg::OFF_RISE_B) begin
         rd_value[7:0] = {cfg_b.len_sel, cfg_b.rise};
      end else if (araddr == pwm_vib_pkg::OFF_FALL_B) begin
         rd_value[6:0] = cfg_b.fall;
      end else if (araddr == pwm_vib_pkg::OFF_MISC_CONFIG) begin
         rd_value[pwm_vib_pkg::BIT_MODE_SEL] = motor_mode_sel;
      end else if (araddr == pwm_vib_pkg::OFF_MOTOR_CTRL) begin
         rd_value[1:0] = motor_duty_sel;
      end else if (araddr == pwm_vib_pkg::OFF_MOTOR_CFG) begin
         rd_value[1:0] = motor_rate_sel;
      end else if (araddr == pwm_vib_pkg::OFF_MOTOR_ACTION) begin
         rd_value[11:0] = {motor_level, motor_state};
      end else if (araddr == pwm_vib_pkg::OFF_STATUS) begin
         rd_value[15:0] = {running_b, period_counter_b,
                           running_a, period_counter_a};
      end else begin
         rd_hit = 1'b0;
      end
   end

   // one request at a time: arready drops while data waits
   assign arready = !rvalid;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rvalid <= 1'b0;
         rdata <= 32'h0000_0000;
         rresp <= pwm_vib_pkg::RESP_OKAY;
      end else if (arvalid && arready) begin
         rvalid <= 1'b1;
         rdata <= rd_value;
         rresp <= rd_hit ? pwm_vib_pkg::RESP_OKAY :
                  pwm_vib_pkg::RESP_SLVERR;
      end else if (rready) begin
         rvalid <= 1'b0;
      end
   end
endmodule

// file: pwm_vib_properties.sv
// checker for the register bus handshakes and the motor drive outputs
// assumes it is bound to the top module and sees only its ports
`timescale 1ns/1ns
module pwm_vib_properties (
   // watched ports
   input wire logic clk, rst, awvalid, awready, wvalid, wready,
   input wire logic bvalid, bready, arvalid, arready, rvalid, rready,
   input wire logic [7:0] araddr, motor_level,
   input wire logic [31:0] rdata,
   input wire logic [1:0] rresp,
   input wire logic motor_mode_sel, motor_drive
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   chk_b_follow: assert property (
      awvalid && awready && wvalid && wready |-> ##[1:2] bvalid)
      else $error("write answer late");
   chk_b_drop: assert property (
      $fell(bvalid) |-> $past(bready)) else $error("bvalid dropped early");
   chk_aw_block: assert property (
      bvalid |-> !awready && !wready) else $error("write taken early");
   chk_r_next: assert property (
      arvalid && arready |=> rvalid) else $error("read answer late");
   chk_r_drop: assert property (
      $fell(rvalid) |-> $past(rready)) else $error("rvalid dropped early");
   chk_r_unmap: assert property (
      arvalid && arready && araddr > 8'h24 |=> rresp == 2'h2 && !rdata)
      else $error("unmapped read answered");
   chk_drive_ok: assert property (
      motor_drive |-> $past(motor_mode_sel) && $past(motor_level) != 8'h00)
      else $error("drive without mode");
   chk_level_step: assert property (
      $changed(motor_level) |-> motor_level - $past(motor_level)
      inside {8'h01, 8'hff}) else $error("level jumped");
endmodule
bind pwm_vib_top pwm_vib_properties props (.clk, .rst, .awvalid,
   .awready, .wvalid, .wready, .bvalid, .bready, .arvalid, .arready,
   .rvalid, .rready, .araddr, .motor_level, .rdata, .rresp,
   .motor_mode_sel, .motor_drive);

// file: pwm_load.sv
// load on the pulse outputs: counts high samples per slow clock
// assumes the slow clock runs free, as the crystal source does
`timescale 1ns/1ns
module pwm_load (
   // pulses and count clear
   input wire logic pwm_a, input wire logic pwm_b, input wire logic clr,
   // slow clock and counts
   output logic slow_clk, output int high_a, output int high_b
);
   initial begin
      slow_clk = 0;
      forever #15259 slow_clk = ~slow_clk;
   end
   // mid-cycle sampling keeps clear of the synchroniser lag
   always @(negedge slow_clk) begin
      high_a <= clr ? 0 : high_a + int'(pwm_a);
      high_b <= clr ? 0 : high_b + int'(pwm_b);
   end
endmodule

// file: dual_pwm_vibrator_control_test.sv
// self-checking bench for the pulse and motor block
// assumes short ramp parameters and the load model on the slow clock
`timescale 1ns/1ns
module dual_pwm_vibrator_control_test;
   logic clk, rst, awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready, sclk, clr, pa, pb, msel, mdrv;
   logic [7:0] awaddr, araddr, mlev;
   logic [31:0] wdata, rdata, d;
   logic [1:0] bresp, rresp, r;
   int high_a, high_b, failures, checks_done;
   typedef struct {logic [7:0] a; logic [31:0] w, e; logic [1:0] r;} row_type;
   row_type rows[9] = '{'{8'h04, 32'h05, 32'h05, 2'h0},
      '{8'h08, 32'h0a, 32'h0a, 2'h0}, '{8'h0c, 32'h83, 32'h83, 2'h0},
      '{8'h10, 32'h03, 32'h03, 2'h0}, '{8'h14, 32'h01, 32'h01, 2'h0},
      '{8'h18, 32'h03, 32'h03, 2'h0}, '{8'h1c, 32'h03, 32'h03, 2'h0},
      '{8'h00, 32'h03, 32'h03, 2'h0}, '{8'h30, 32'h5a, 32'h00, 2'h2}};
   pwm_vib_top #(.RAMP_ON_CYCLES(255), .RAMP_OFF_CYCLES(510)) pwm_vib_top_inst (
      .clk, .rst, .awvalid, .awready, .awaddr, .awprot(3'h0), .wvalid,
      .wready, .wdata, .wstrb(4'hf), .bvalid, .bready, .bresp, .arvalid,
      .arready, .araddr, .arprot(3'h0), .rvalid, .rready, .rdata, .rresp,
      .clk32k_in(sclk), .pwm_out_a(pa), .pwm_out_b(pb),
      .motor_mode_sel(msel), .motor_level(mlev), .motor_drive(mdrv));
   pwm_load pwm_load_inst (.pwm_a(pa), .pwm_b(pb), .clr, .slow_clk(sclk),
      .high_a, .high_b);
   task cmp(input logic [33:0] g, input logic [33:0] e);
      checks_done++;
      if (g !== e) begin
         failures++;
         $display("[FAIL] %0t got %h want %h", $time, g, e);
      end
   endtask
   task results;
      if (failures == 0 && checks_done > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // ready is sampled mid-cycle, so the release lands on the taking edge
   task wr(input logic [7:0] a, input logic [31:0] w, output logic [1:0] b);
      logic ha, hw, hb;
      @(posedge clk);
      awaddr <= a; wdata <= w; awvalid <= 1; wvalid <= 1; bready <= 1;
      hb = 0;
      for (int n = 0; n < 99 && !hb; n++) begin
         @(negedge clk); ha = awready; hw = wready; hb = bvalid; b = bresp;
         @(posedge clk);
         if (ha) awvalid <= 0;
         if (hw) wvalid <= 0;
      end
      bready <= 0;
      if (!hb) failures++;
   endtask
   task rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] b);
      logic hr, hv;
      @(posedge clk);
      araddr <= a; arvalid <= 1; rready <= 1; hv = 0;
      for (int n = 0; n < 99 && !hv; n++) begin
         @(negedge clk); hr = arready; hv = rvalid; v = rdata; b = rresp;
         @(posedge clk);
         if (hr) arvalid <= 0;
      end
      rready <= 0;
      if (!hv) failures++;
   endtask
   initial begin
      clk = 0;
      forever #25 clk = ~clk;
   end
   initial begin
      #4900000 failures++;
      results;
   end
   initial begin
      rst = 1; awvalid = 0; wvalid = 0; bready = 0; arvalid = 0; rready = 0;
      awaddr = 8'h00; araddr = 8'h00; wdata = 32'h0; clr = 1;
      repeat (10) @(posedge clk);
      rst <= 0;
      rd(8'h04, d, r); cmp(d, 32'h81);
      cmp({pa, pb, mdrv}, 3'h0);
      foreach (rows[i]) begin
         wr(rows[i].a, rows[i].w, r); cmp(r, rows[i].r);
         rd(rows[i].a, d, r); cmp({r, d}, {rows[i].r, rows[i].e});
      end
      wr(8'h00, 32'h0f, r);
      rd(8'h24, d, r);
      cmp({d[15], d[7], d[14:8]}, {2'b11, d[6:0]});
      @(posedge sclk) clr = 0;
      repeat (128) @(posedge sclk);
      cmp(high_a, 32'd10);
      cmp(high_b, 32'd128);
      wr(8'h00, 32'h13, r); wr(8'h00, 32'h03, r);
      repeat (2) @(posedge sclk);
      @(negedge clk) cmp({pa, pb}, 2'b01);
      wr(8'h20, 32'h01, r); repeat (300) @(posedge clk);
      @(negedge clk) cmp({msel, mlev, mdrv}, 10'h3ff);
      wr(8'h20, 32'h02, r); repeat (560) @(posedge clk);
      @(negedge clk) cmp({mlev, mdrv}, 9'h000);
      rst <= 1;
      @(posedge clk) rst <= 0;
      @(negedge clk) cmp({pa, pb}, 2'b00);
      rd(8'h04, d, r); cmp(d, 32'h81);
      results;
   end
endmodule
